// >>> sdv_pkg.sv
package sdv_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ADDR_PRESET3 = 8'h35;
   localparam logic [7:0] ADDR_PRESET4 = 8'h36;
   localparam logic [7:0] ADDR_RANGE_RAMP = 8'h37;
   localparam logic [7:0] ADDR_ENABLE_GOOD = 8'h38;
   localparam logic [7:0] ADDR_PRIMARY = 8'h32;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [6:0] RST_PRESET3 = 7'h54;
   localparam logic [6:0] RST_PRESET4 = 7'h20;
   localparam logic [6:0] RST_PRIMARY = 7'h38;
   localparam logic RST_WIDE_RANGE = 1'h1;
   localparam logic [1:0] RST_RAMP = 2'h0;
   localparam logic [2:0] RST_ENABLE_MODE = 3'h0;
   localparam logic RST_GOOD_MON = 1'h1;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int WIDE_RANGE_BIT = 5;
   localparam int RAMP_LSB = 3;
   localparam int MODE_LSB = 5;
   localparam int GOOD_MON_BIT = 3;
   localparam int GOOD_FLAG_BIT = 1;

   // ****************************************
   // Enable modes
   // ****************************************
   localparam logic [2:0] MODE_SEQ_D = 3'h3;
   localparam logic [2:0] MODE_OFF = 3'h4;
   localparam logic [2:0] MODE_ON = 3'h5;
   localparam logic [2:0] MODE_PIN = 3'h6;
   localparam logic [2:0] MODE_RSVD = 3'h7;

   // ****************************************
   // Ramp rates
   // ****************************************
   localparam logic [1:0] RAMP_INSTANT = 2'h0;
   localparam logic [1:0] RAMP_FAST = 2'h1;
   localparam logic [1:0] RAMP_MID = 2'h2;
   localparam logic [1:0] RAMP_SLOW = 2'h3;

   // Reference step time per rate, in ns per 12.5 mV fine step
   localparam int CLK_PERIOD_NS = 5;
   localparam int STEP_NS_FAST = 2500;
   localparam int STEP_NS_MID = 12500;
   localparam int STEP_NS_SLOW = 125000;
   localparam logic [15:0] STEP_CYC_FAST = 16'(STEP_NS_FAST / CLK_PERIOD_NS);
   localparam logic [15:0] STEP_CYC_MID = 16'(STEP_NS_MID / CLK_PERIOD_NS);
   localparam logic [15:0] STEP_CYC_SLOW = 16'(STEP_NS_SLOW / CLK_PERIOD_NS);

   // ****************************************
   // Code to fine units (12.5 mV above 0.4 V)
   // ****************************************
   localparam logic [9:0] WIDE_KNEE_CODE = 10'h70;
   localparam logic [9:0] WIDE_KNEE_FINE = 10'he0;
   localparam logic [9:0] WIDE_TOP_CODE = 10'h78;
   localparam logic [9:0] WIDE_TOP_FINE = 10'h100;

   typedef enum logic [2:0] {
      SDV_IDLE = 3'b001,
      SDV_WAIT = 3'b010,
      SDV_STEP = 3'b100
   } sdv_ramp_e;
endpackage

// >>> sdv_ramp.sv
`timescale 1ns/1ps
module sdv_ramp (
   // Clocking
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic softRst,
   // Control
   input wire logic [9:0] target,
   input wire logic [1:0] rate,
   // Reference
   output logic [9:0] reference
);
   import sdv_pkg::*;

   sdv_ramp_e state_reg, state_next;
   logic [9:0] ref_reg, ref_next;
   logic [15:0] cnt_reg, cnt_next;
   wire logic [15:0] stepCyc;
   wire logic differ;

   assign differ = (ref_reg != target);
   assign stepCyc = (rate == RAMP_FAST) ? STEP_CYC_FAST :
                    (rate == RAMP_MID) ? STEP_CYC_MID : STEP_CYC_SLOW;
   assign reference = ref_reg;

   always_comb begin
      state_next = state_reg;
      ref_next = ref_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         SDV_IDLE: begin
            if (differ && rate == RAMP_INSTANT) begin
               ref_next = target;
            end else if (differ) begin
               cnt_next = stepCyc - 16'h1;
               state_next = SDV_WAIT;
            end
         end
         SDV_WAIT: begin
            if (rate == RAMP_INSTANT || !differ) begin
               state_next = SDV_IDLE;
            end else if (cnt_reg == 16'h0) begin
               state_next = SDV_STEP;
            end else begin
               cnt_next = cnt_reg - 16'h1;
            end
         end
         SDV_STEP: begin
            if (ref_reg < target) begin
               ref_next = ref_reg + 10'h1;
            end else if (ref_reg > target) begin
               ref_next = ref_reg - 10'h1;
            end
            state_next = SDV_IDLE;
         end
         default: state_next = SDV_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= SDV_IDLE;
         ref_reg <= 10'h0;
         cnt_reg <= 16'h0;
      end else if (clkEn) begin
         if (softRst) begin
            state_reg <= SDV_IDLE;
            cnt_reg <= 16'h0;
            ref_reg <= target;
         end else begin
            state_reg <= state_next;
            ref_reg <= ref_next;
            cnt_reg <= cnt_next;
         end
      end
   end
endmodule // sdv_ramp

// >>> sdv_dvs_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Preset three code, reset 54h
// - Preset four code, reset 20h
// - Narrow range: 12.5 mV steps to 1.575 V
// - Wide range: 25 mV, then 50 mV steps
// - Modes 000-011: sequenced at slot a-d
// - Mode 100 off, 101 on, unsequenced
// - Mode 110 pin controlled; 111 reserved
// - Bit 3 enables output good monitoring
// - Bit 1 reports output good, read only
// - Primary code writable or mirrors pin preset
module sdv_dvs_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic softRst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   // Preset selection and pins
   input wire logic pinSelect,
   input wire logic [1:0] pinPreset,
   input wire logic [6:0] preset1Code,
   input wire logic [6:0] preset2Code,
   input wire logic thirdGeneralPin,
   // Sequencer and converter
   input wire logic [3:0] seqSlotActive,
   input wire logic outputGood,
   output logic convEnable,
   output logic inSequence,
   output logic [1:0] seqSlot,
   output logic goodMonEnable,
   output logic wideRange,
   output logic [9:0] referenceFine
);
   import sdv_pkg::*;

   // ****************************************
   // Storage
   // ****************************************
   logic [6:0] preset3_reg;
   logic [6:0] preset4_reg;
   logic [6:0] primary_reg;
   logic wide_reg;
   logic [1:0] ramp_reg;
   logic [2:0] mode_reg;
   logic goodMon_reg;
   logic good_reg;
   logic [7:0] rdData_reg;
   logic convEn_reg;
   logic inSeq_reg;
   logic [1:0] slot_reg;
   logic wideOut_reg;
   logic monOut_reg;
   logic [9:0] refOut_reg;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [9:0] code_to_fine(input logic [6:0] code,
                                               input logic wide);
      logic [9:0] c;
      c = {3'h0, code};
      if (!wide) begin
         code_to_fine = c;
      end else if (c <= WIDE_KNEE_CODE) begin
         code_to_fine = {c[8:0], 1'b0};
      end else if (c > WIDE_TOP_CODE) begin
         // Codes past the top hold at full scale
         code_to_fine = WIDE_TOP_FINE;
      end else begin
         code_to_fine = WIDE_KNEE_FINE + {c[7:0] - WIDE_KNEE_CODE[7:0], 2'b00};
      end
   endfunction

   // ****************************************
   // Decode
   // ****************************************
   wire logic hitP3 = (regAddr == ADDR_PRESET3);
   wire logic hitP4 = (regAddr == ADDR_PRESET4);
   wire logic hitRr = (regAddr == ADDR_RANGE_RAMP);
   wire logic hitEg = (regAddr == ADDR_ENABLE_GOOD);
   wire logic hitPr = (regAddr == ADDR_PRIMARY);
   wire logic wrP3 = regWrEn && hitP3;
   wire logic wrP4 = regWrEn && hitP4;
   wire logic wrRr = regWrEn && hitRr;
   wire logic wrEg = regWrEn && hitEg &&
                     regWrData[MODE_LSB +: 3] != MODE_RSVD;
   wire logic wrPr = regWrEn && hitPr && !pinSelect;

   wire logic [6:0] pinCode;
   assign pinCode = (pinPreset == 2'h0) ? preset1Code :
                    (pinPreset == 2'h1) ? preset2Code :
                    (pinPreset == 2'h2) ? preset3_reg : preset4_reg;
   wire logic [6:0] activeCode;
   assign activeCode = pinSelect ? pinCode : primary_reg;

   wire logic [7:0] rdRangeRamp;
   assign rdRangeRamp = (8'(wide_reg) << WIDE_RANGE_BIT) |
                        (8'(ramp_reg) << RAMP_LSB);
   wire logic [7:0] rdEnableGood;
   assign rdEnableGood = (8'(mode_reg) << MODE_LSB) |
                         (8'(goodMon_reg) << GOOD_MON_BIT) |
                         (8'(good_reg) << GOOD_FLAG_BIT);

   wire logic [7:0] rdMux;
   assign rdMux = hitP3 ? {1'b0, preset3_reg} :
                  hitP4 ? {1'b0, preset4_reg} :
                  hitRr ? rdRangeRamp :
                  hitEg ? rdEnableGood :
                  hitPr ? {1'b0, activeCode} : 8'h00;

   // ****************************************
   // Enable mode
   // ****************************************
   wire logic modeSeq = (mode_reg <= MODE_SEQ_D);
   wire logic enNext;
   assign enNext = modeSeq ? seqSlotActive[mode_reg[1:0]] :
                   (mode_reg == MODE_ON) ? 1'b1 :
                   (mode_reg == MODE_PIN) ? thirdGeneralPin :
                   1'b0;

   // ****************************************
   // Ramp
   // ****************************************
   wire logic [9:0] rampRef;
   sdv_ramp u_ramp (
      .clk(clk),
      .rst(rst),
      .clkEn(clkEn),
      .softRst(softRst),
      .target(code_to_fine(activeCode, wide_reg)),
      .rate(ramp_reg),
      .reference(rampRef)
   );

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         preset3_reg <= RST_PRESET3;
         preset4_reg <= RST_PRESET4;
         primary_reg <= RST_PRIMARY;
         wide_reg <= RST_WIDE_RANGE;
         ramp_reg <= RST_RAMP;
         mode_reg <= RST_ENABLE_MODE;
         goodMon_reg <= RST_GOOD_MON;
      end else if (clkEn) begin
         if (softRst) begin
            preset3_reg <= RST_PRESET3;
            preset4_reg <= RST_PRESET4;
            primary_reg <= RST_PRIMARY;
            wide_reg <= RST_WIDE_RANGE;
            ramp_reg <= RST_RAMP;
            mode_reg <= RST_ENABLE_MODE;
            goodMon_reg <= RST_GOOD_MON;
         end else begin
            if (wrP3) begin
               preset3_reg <= regWrData[6:0];
            end
            if (wrP4) begin
               preset4_reg <= regWrData[6:0];
            end
            if (wrPr) begin
               primary_reg <= regWrData[6:0];
            end
            if (wrRr) begin
               wide_reg <= regWrData[WIDE_RANGE_BIT];
               ramp_reg <= regWrData[RAMP_LSB +: 2];
            end
            if (wrEg) begin
               mode_reg <= regWrData[MODE_LSB +: 3];
               goodMon_reg <= regWrData[GOOD_MON_BIT];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         good_reg <= 1'b0;
         rdData_reg <= 8'h00;
         convEn_reg <= 1'b0;
         inSeq_reg <= 1'b0;
         slot_reg <= 2'h0;
         wideOut_reg <= 1'b0;
         monOut_reg <= 1'b0;
         refOut_reg <= 10'h0;
      end else if (clkEn) begin
         good_reg <= outputGood;
         if (regRdEn) begin
            rdData_reg <= rdMux;
         end
         convEn_reg <= enNext;
         inSeq_reg <= modeSeq;
         slot_reg <= mode_reg[1:0];
         wideOut_reg <= wide_reg;
         monOut_reg <= goodMon_reg;
         refOut_reg <= rampRef;
      end
   end

   assign regRdData = rdData_reg;
   assign convEnable = convEn_reg;
   assign inSequence = inSeq_reg;
   assign seqSlot = slot_reg;
   assign goodMonEnable = monOut_reg;
   assign wideRange = wideOut_reg;
   assign referenceFine = refOut_reg;
endmodule // sdv_dvs_regs

// >>> sdv_dvs_regs_properties.sv
`timescale 1ns/1ps
// ******
// Checker
// ******
module sdv_dvs_regs_properties
   import sdv_pkg::*;
(
   // Register port
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic softRst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   // Converter side
   input wire logic [3:0] seqSlotActive,
   input wire logic convEnable,
   input wire logic inSequence,
   input wire logic [1:0] seqSlot,
   input wire logic goodMonEnable,
   input wire logic wideRange,
   input wire logic [9:0] referenceFine
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire wrT = clkEn && regWrEn && !softRst;
   wire rdT = clkEn && regRdEn;
   wire wr38 = wrT && regAddr == ADDR_ENABLE_GOOD;
   wire rsvdMode = regWrData[7:5] == MODE_RSVD;
   logic [3:0] slotPrev;
   always_ff @(posedge clk) slotPrev <= seqSlotActive;
   function automatic logic [7:0] zeroMask(logic [7:0] a);
      case (a)
         ADDR_PRIMARY, ADDR_PRESET3, ADDR_PRESET4: return 8'h80;
         ADDR_RANGE_RAMP: return 8'hc7;
         ADDR_ENABLE_GOOD: return 8'h15;
         default: return 8'hff;
      endcase
   endfunction
   property p_wide;
      wrT && regAddr == ADDR_RANGE_RAMP ##1 clkEn && !softRst
         |-> ##1 wideRange == $past(regWrData[5], 2);
   endproperty
   a_wide: assert property (p_wide) else $error("range bit");
   property p_mon;
      wr38 && !rsvdMode ##1 clkEn && !softRst
         |-> ##1 goodMonEnable == $past(regWrData[3], 2);
   endproperty
   a_mon: assert property (p_mon) else $error("monitor bit");
   property p_rej;
      wr38 && rsvdMode ##1 clkEn && !softRst
         |-> ##1 $stable(goodMonEnable) && $stable(seqSlot);
   endproperty
   a_rej: assert property (p_rej) else $error("mode 7 taken");
   property p_rsvd;
      rdT |=> (regRdData & zeroMask($past(regAddr))) == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits");
   property p_soft;
      clkEn && softRst ##1 clkEn && !softRst
         |-> ##1 wideRange && goodMonEnable && inSequence && seqSlot == 2'h0;
   endproperty
   a_soft: assert property (p_soft) else $error("soft rst");
   property p_seq;
      $past(clkEn) && inSequence |-> convEnable == slotPrev[seqSlot];
   endproperty
   a_seq: assert property (p_seq) else $error("slot enable");
   property p_fixed;
      rdT && regAddr == ADDR_ENABLE_GOOD |=> inSequence == !regRdData[7]
         && (regRdData[7:6] != 2'b10 || convEnable == regRdData[5]);
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed mode");
   property p_ref;
      referenceFine <= 10'h100;
   endproperty
   a_ref: assert property (p_ref) else $error("reference span");
   cover property (wrT && regAddr == ADDR_RANGE_RAMP);
   cover property (wr38 && rsvdMode);
   cover property (inSequence && convEnable);
endmodule // sdv_dvs_regs_properties
bind sdv_dvs_regs sdv_dvs_regs_properties u_props (.*);

// >>> sdv_host_model.sv
`timescale 1ns/1ps
// ******
// Register host
// ******
module sdv_host_model (
   // Clock
   input wire logic clk,
   // Register port
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   output logic regWrEn,
   output logic regRdEn,
   input wire logic [7:0] regRdData
);
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   // Mode 7 goes out only when the caller asks
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWrEn <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~v;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      @(posedge clk);
      v = regRdData;
   endtask
endmodule // sdv_host_model

// >>> testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
   import sdv_pkg::*;
   logic clk = 0, rst = 1, softRst = 0, pinSelect = 0, thirdGeneralPin = 0;
   logic outputGood = 0, clkEn = 1, w, ex;
   logic [1:0] pinPreset = 0;
   logic [6:0] preset1Code = 0, preset2Code = 0, c;
   logic [3:0] seqSlotActive = 0;
   logic [7:0] regAddr, regWrData, regRdData, d, ad, mdl [256];
   logic regWrEn, regRdEn, convEnable, inSequence, goodMonEnable, wideRange;
   logic [1:0] seqSlot;
   logic [9:0] referenceFine;
   int n_mismatch = 0, compares = 0, seed = 18, cyc = 0, n;
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 60000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   sdv_host_model u_host (.*);
   sdv_dvs_regs u_dut (.*);
   function automatic logic [6:0] act();
      if (!pinSelect) return mdl[ADDR_PRIMARY][6:0];
      case (pinPreset)
         2'h0: return preset1Code;
         2'h1: return preset2Code;
         2'h2: return mdl[ADDR_PRESET3][6:0];
         default: return mdl[ADDR_PRESET4][6:0];
      endcase
   endfunction
   function automatic logic [9:0] fine(logic [6:0] k, logic wd);
      if (!wd) return {3'h0, k};
      if (k <= 7'h70) return {2'h0, k, 1'b0};
      if (k >= 7'h78) return 10'h100;
      return 10'h0e0 + {1'b0, 7'(k - 7'h70), 2'h0};
   endfunction
   task mreset;
      mdl = '{default: 8'h00};
      mdl[8'h32] = 8'h38;
      mdl[8'h35] = 8'h54;
      mdl[8'h36] = 8'h20;
      mdl[8'h37] = 8'h20;
      mdl[8'h38] = 8'h08;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      u_host.wr(a, v);
      case (a)
         8'h35, 8'h36: mdl[a] = v & 8'h7f;
         8'h32: if (!pinSelect) mdl[a] = v & 8'h7f;
         8'h37: mdl[a] = v & 8'h38;
         8'h38: if (v[7:5] != 3'h7) mdl[a] = v & 8'he8;
         default: ;
      endcase
   endtask
   task rd(input logic [7:0] a);
      logic [7:0] e;
      u_host.rd(a, d);
      e = mdl[a];
      if (a == 8'h32) e = {1'b0, act()};
      if (a == 8'h38) e[1] = outputGood;
      `CHK("reg", e, d)
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task chkRef;
      `CHK("ref", fine(act(), mdl[8'h37][5]), referenceFine)
   endtask
   task wrap_up;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      mreset;
      tick(4);
      rst <= 1'b0;
      tick(4);
      for (int a = 8'h30; a < 8'h3b; a++) rd(8'(a));
      chkRef;
      $display("done reset");
      repeat (30) begin
         ad = 8'h30 + 8'($unsigned($random(seed)) % 11);
         wr(ad, 8'($random(seed)) & (ad == 8'h37 ? 8'he7 : 8'hff));
         rd(ad);
         outputGood <= $random(seed);
      end
      $display("done random");
      wr(8'h32, 8'h20);
      repeat (8) begin
         w = $random(seed);
         c = 7'($unsigned($random(seed)) % (w ? 8'h78 : 8'h5f));
         wr(8'h37, {2'h0, w, 5'h00});
         wr(8'h32, {1'b0, c});
         tick(4);
         chkRef;
         `CHK("wide", w, wideRange)
      end
      $display("done range");
      wr(8'h37, 8'h00);
      wr(8'h32, 8'h30);
      for (int r = 1; r < 4; r++) begin
         n = r == 1 ? 500 : r == 2 ? 2500 : 25000;
         wr(8'h37, 8'(r << 3));
         c = mdl[8'h32][6:0];
         wr(8'h32, {1'b0, r == 2 ? c - 7'h01 : c + 7'h01});
         tick(n / 2);
         `CHK("ramp", fine(c, 1'b0), referenceFine)
         tick(n);
         chkRef;
      end
      wr(8'h37, 8'h20);
      wr(8'h35, 8'($unsigned($random(seed)) % 8'h78));
      wr(8'h36, 8'($unsigned($random(seed)) % 8'h78));
      preset1Code <= 7'($unsigned($random(seed)) % 8'h78);
      preset2Code <= 7'($unsigned($random(seed)) % 8'h78);
      pinSelect <= 1'b1;
      tick(1);
      for (int p = 0; p < 4; p++) begin
         pinPreset <= 2'(p);
         wr(8'h32, 8'($random(seed)));
         rd(8'h32);
         tick(4);
         chkRef;
      end
      pinSelect <= 1'b0;
      $display("done pins");
      for (int m = 0; m < 8; m++) begin
         seqSlotActive <= 4'($random(seed));
         thirdGeneralPin <= $random(seed);
         wr(8'h38, {3'(m), 1'b0, 1'(m), 3'h0});
         tick(3);
         rd(8'h38);
         c = {4'h0, mdl[8'h38][7:5]};
         ex = c < 4 ? seqSlotActive[c[1:0]] :
              c == 5 || (c == 6 && thirdGeneralPin);
         `CHK("enable", ex, convEnable)
         `CHK("inseq", c < 4, inSequence)
         `CHK("slot", c[1:0], seqSlot)
         `CHK("mon", mdl[8'h38][3], goodMonEnable)
      end
      $display("done modes");
      clkEn <= 1'b0;
      u_host.wr(8'h35, 8'h7f ^ mdl[8'h35]);
      clkEn <= 1'b1;
      rd(8'h35);
      $display("done freeze");
      wr(8'h35, 8'h01);
      wr(8'h37, 8'h00);
      softRst <= 1'b1;
      tick(1);
      softRst <= 1'b0;
      mreset;
      tick(3);
      for (int a = 8'h32; a < 8'h39; a++) rd(8'(a));
      chkRef;
      $display("done soft reset");
      wrap_up;
   end
endmodule // testbench
